// *** pkg/ashrc_pkg.sv ***
// Shared constants and types of the accelerometer status, hold and reset control.
// Assumes a single 25 MHz core clock on both ends.
package ashrc_pkg;

  // Clock and timing
  localparam int unsigned CLK_KHZ       = 25000;
  localparam int unsigned RST_HOLD_US   = 512;
  localparam int unsigned RST_HOLD_CYC  = (RST_HOLD_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned HIZ_US        = 800;
  localparam int unsigned HIZ_CYC       = (HIZ_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned STAB_MS       = 3;
  localparam int unsigned STAB_CYC      = STAB_MS * CLK_KHZ;
  localparam int unsigned SAMPLE_US     = 16;
  localparam int unsigned SAMPLE_CYC    = (SAMPLE_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned RST_MARGIN_CYC = 4;
  localparam int unsigned ST_PULSE_CYC  = 4;

  // Widths
  localparam int unsigned TMR_W  = 17;
  localparam int unsigned DATA_W = 16;

  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  typedef logic [TMR_W-1:0]  ashrc_tmr_t;
  typedef logic [DATA_W-1:0] ashrc_data_t;

  // Device sequencing after any reset
  typedef enum logic [1:0] {
    ASHRC_PH_HIZ  = 2'b00,
    ASHRC_PH_STAB = 2'b01,
    ASHRC_PH_RUN  = 2'b10
  } ashrc_phase_e;

  // Controller activity
  typedef enum logic [1:0] {
    ASHRC_CS_IDLE = 2'b00,
    ASHRC_CS_RST  = 2'b01,
    ASHRC_CS_CLR  = 2'b10
  } ashrc_cstate_e;

endpackage

// *** pkg/ashrc_if.sv ***
// Pin-level link between the accelerometer control and its system controller.
// Reset and serial clock pins are released by the controller when undriven.
interface ashrc_if;
  logic reset_pin_val;
  logic reset_pin_oe_n;
  logic sclk_val;
  logic sclk_oe_n;
  logic self_test_pin;
  logic sample_freeze_input;
  logic status_val;
  logic status_oe_n;

  modport dev (
    input  reset_pin_val, reset_pin_oe_n, sclk_val, sclk_oe_n,
    input  self_test_pin, sample_freeze_input,
    output status_val, status_oe_n
  );

  modport ctl (
    output reset_pin_val, reset_pin_oe_n, sclk_val, sclk_oe_n,
    output self_test_pin, sample_freeze_input,
    input  status_val, status_oe_n
  );
endinterface

// *** hw/ashrc_dev.sv ***
// Device end: reset detector, status latch and sequencing, self-test, sample hold.
// Assumes pins synchronous to core_clk_i; filtered samples arrive from the user side.

module ashrc_dev #(
  parameter int unsigned RST_CYC  = ashrc_pkg::RST_HOLD_CYC,
  parameter int unsigned HIZ_CYC  = ashrc_pkg::HIZ_CYC,
  parameter int unsigned STAB_CYC = ashrc_pkg::STAB_CYC
) (
  // Clock, reset, enable
  input  wire logic                core_clk_i,
  input  wire logic                rstn_i,
  input  wire logic                ce_i,
  // Pins
  ashrc_if.dev                     pins,
  // Fault sources
  input  wire logic                parity_fault_i,
  input  wire logic                over_temp_i,
  input  wire logic                clk_fault_i,
  input  wire logic                terminal_fault_i,
  // Filtered samples
  input  wire ashrc_pkg::ashrc_data_t x_sample_i,
  input  wire ashrc_pkg::ashrc_data_t y_sample_i,
  output logic                     sample_strobe_o,
  // Converter data
  output ashrc_pkg::ashrc_data_t   x_dac_o,
  output ashrc_pkg::ashrc_data_t   y_dac_o,
  // Status and control
  output logic                     self_test_active_o,
  output logic                     serial_port_en_o,
  output logic                     dev_reset_o,
  output logic                     stab_busy_o
);

  typedef struct packed {
    ashrc_pkg::ashrc_phase_e phase;
    ashrc_pkg::ashrc_tmr_t   tmr;
    ashrc_pkg::ashrc_tmr_t   rst_cnt;
    ashrc_pkg::ashrc_tmr_t   smp_cnt;
    logic                    st_s1;
    logic                    st_s2;
    logic                    st_s3;
    logic                    frz_d;
    logic                    frozen;
    logic                    latch;
    logic                    rst_pulse;
    logic                    strobe;
    ashrc_pkg::ashrc_data_t  x_out;
    ashrc_pkg::ashrc_data_t  y_out;
  } ashrc_dev_s;

  localparam ashrc_dev_s DEV_RST = '{
    phase:    ashrc_pkg::ASHRC_PH_HIZ,
    tmr:      '0,
    rst_cnt:  '0,
    smp_cnt:  '0,
    st_s1:    1'b0,
    st_s2:    1'b0,
    st_s3:    1'b0,
    frz_d:    1'b0,
    frozen:   1'b0,
    latch:    1'b1,
    rst_pulse: 1'b0,
    strobe:   1'b0,
    x_out:    ashrc_pkg::DATA_RST,
    y_out:    ashrc_pkg::DATA_RST
  };

  // Last count value of a period
  function automatic ashrc_pkg::ashrc_tmr_t last_of(input int unsigned cyc);
    last_of = ashrc_pkg::TMR_W'(cyc - 1);
  endfunction

  ashrc_dev_s s;
  ashrc_dev_s next_s;

  logic reset_level;
  logic sclk_level;
  logic rst_cond;
  logic st_rise;
  logic frz_rise;
  logic fault_any;

  always_comb begin
    reset_level = pins.reset_pin_oe_n ? 1'b1 : pins.reset_pin_val;
    sclk_level  = pins.sclk_oe_n ? 1'b0 : pins.sclk_val;
    rst_cond    = !reset_level && sclk_level;
    st_rise     = s.st_s2 && !s.st_s3;
    frz_rise    = pins.sample_freeze_input && !s.frz_d;
    fault_any   = parity_fault_i || over_temp_i || clk_fault_i;
  end

  always_comb begin
    next_s           = s;
    next_s.rst_pulse = 1'b0;
    next_s.strobe    = 1'b0;
    next_s.st_s1     = pins.self_test_pin;
    next_s.st_s2     = s.st_s1;
    next_s.st_s3     = s.st_s2;
    next_s.frz_d     = pins.sample_freeze_input;

    // Pin reset detector; saturates so one hold gives one reset
    if (!rst_cond) begin
      next_s.rst_cnt = '0;
    end else if (s.rst_cnt != ashrc_pkg::TMR_W'(RST_CYC)) begin
      next_s.rst_cnt = s.rst_cnt + 1'b1;
      if (s.rst_cnt == last_of(RST_CYC)) begin
        next_s.rst_pulse = 1'b1;
      end
    end

    // Sample timebase
    if (s.smp_cnt == last_of(ashrc_pkg::SAMPLE_CYC)) begin
      next_s.smp_cnt = '0;
      next_s.strobe  = 1'b1;
    end else begin
      next_s.smp_cnt = s.smp_cnt + 1'b1;
    end

    // Hold control
    if (!pins.sample_freeze_input) begin
      next_s.frozen = 1'b0;
    end else if (frz_rise) begin
      next_s.frozen = 1'b1;
    end
    if (s.strobe && !next_s.frozen) begin
      next_s.x_out = x_sample_i;
      next_s.y_out = y_sample_i;
    end

    // Status sequencing and latch
    case (s.phase)
      ashrc_pkg::ASHRC_PH_HIZ: begin
        next_s.latch = 1'b1;
        if (s.tmr == last_of(HIZ_CYC)) begin
          next_s.tmr   = '0;
          next_s.phase = ashrc_pkg::ASHRC_PH_STAB;
        end else begin
          next_s.tmr = s.tmr + 1'b1;
        end
      end
      ashrc_pkg::ASHRC_PH_STAB: begin
        next_s.latch = 1'b1;
        if (s.tmr == last_of(STAB_CYC)) begin
          next_s.tmr   = '0;
          next_s.phase = ashrc_pkg::ASHRC_PH_RUN;
        end else begin
          next_s.tmr = s.tmr + 1'b1;
        end
      end
      ashrc_pkg::ASHRC_PH_RUN: begin
        // Set wins over a clear in the same cycle
        next_s.latch = fault_any || terminal_fault_i
                       || (s.latch && !st_rise);
      end
      default: begin
        next_s.phase = ashrc_pkg::ASHRC_PH_HIZ;
        next_s.tmr   = '0;
      end
    endcase

    // Internal reset restarts the power-up sequence
    if (s.rst_pulse) begin
      next_s.phase  = ashrc_pkg::ASHRC_PH_HIZ;
      next_s.tmr    = '0;
      next_s.latch  = 1'b1;
      // Held outputs return to DATA_RST on an internal reset; the frozen flag is kept
      next_s.x_out  = ashrc_pkg::DATA_RST;
      next_s.y_out  = ashrc_pkg::DATA_RST;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= DEV_RST;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  always_comb begin
    pins.status_oe_n   = (s.phase == ashrc_pkg::ASHRC_PH_HIZ);
    pins.status_val    = s.latch;
    self_test_active_o = s.st_s2;
    serial_port_en_o   = 1'b0;
    dev_reset_o        = s.rst_pulse;
    stab_busy_o        = (s.phase != ashrc_pkg::ASHRC_PH_RUN);
    sample_strobe_o    = s.strobe;
    x_dac_o            = s.x_out;
    y_dac_o            = s.y_out;
  end

endmodule

// *** hw/ashrc_ctl.sv ***
// Controller end: drives reset, serial clock, self-test and freeze pins, watches status.
// Assumes the device end on the same 25 MHz clock.
module ashrc_ctl #(
  parameter int unsigned RST_CYC = ashrc_pkg::RST_HOLD_CYC
) (
  // Clock, reset, enable
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  // Pins
  ashrc_if.ctl      pins,
  // User requests
  input  wire logic reset_req_i,
  input  wire logic clear_req_i,
  input  wire logic self_test_i,
  input  wire logic freeze_i,
  // User status
  output logic      fault_o,
  output logic      status_hiz_o,
  output logic      busy_o
);

  typedef struct packed {
    ashrc_pkg::ashrc_cstate_e state;
    ashrc_pkg::ashrc_tmr_t    tmr;
    logic                     fault;
    logic                     hiz;
  } ashrc_ctl_s;

  localparam ashrc_ctl_s CTL_RST = '{
    state: ashrc_pkg::ASHRC_CS_IDLE,
    tmr:   '0,
    fault: 1'b0,
    hiz:   1'b1
  };

  ashrc_ctl_s s;
  ashrc_ctl_s next_s;

  always_comb begin
    next_s       = s;
    next_s.hiz   = pins.status_oe_n;
    next_s.fault = !pins.status_oe_n && pins.status_val;
    case (s.state)
      ashrc_pkg::ASHRC_CS_IDLE: begin
        next_s.tmr = '0;
        if (reset_req_i) begin
          next_s.state = ashrc_pkg::ASHRC_CS_RST;
        end else if (clear_req_i && !self_test_i) begin
          next_s.state = ashrc_pkg::ASHRC_CS_CLR;
        end
      end
      ashrc_pkg::ASHRC_CS_RST: begin
        // Hold both levels past the full qualifying interval
        if (s.tmr == ashrc_pkg::TMR_W'(RST_CYC + ashrc_pkg::RST_MARGIN_CYC - 1)) begin
          next_s.state = ashrc_pkg::ASHRC_CS_IDLE;
          next_s.tmr   = '0;
        end else begin
          next_s.tmr = s.tmr + 1'b1;
        end
      end
      ashrc_pkg::ASHRC_CS_CLR: begin
        if (s.tmr == ashrc_pkg::TMR_W'(ashrc_pkg::ST_PULSE_CYC - 1)) begin
          next_s.state = ashrc_pkg::ASHRC_CS_IDLE;
          next_s.tmr   = '0;
        end else begin
          next_s.tmr = s.tmr + 1'b1;
        end
      end
      default: begin
        next_s.state = ashrc_pkg::ASHRC_CS_IDLE;
        next_s.tmr   = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= CTL_RST;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  always_comb begin
    // Reset and serial clock pins released outside a reset request
    pins.reset_pin_val       = 1'b0;
    pins.reset_pin_oe_n      = (s.state != ashrc_pkg::ASHRC_CS_RST);
    pins.sclk_val            = 1'b1;
    pins.sclk_oe_n           = (s.state != ashrc_pkg::ASHRC_CS_RST);
    pins.self_test_pin       = self_test_i || (s.state == ashrc_pkg::ASHRC_CS_CLR);
    pins.sample_freeze_input = freeze_i;
    fault_o                  = s.fault;
    status_hiz_o             = s.hiz;
    busy_o                   = (s.state != ashrc_pkg::ASHRC_CS_IDLE);
  end

endmodule

// *** bench/ashrc_monitor.sv ***
// Assertions on the pin link between the two ends.
// Assumes one clock domain; counts reduced by parameters.
module ashrc_monitor #(
  parameter int unsigned RST_CYC  = 16,
  parameter int unsigned HIZ_CYC  = 20,
  parameter int unsigned STAB_CYC = 40
) (
  // Clock, reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Link
  input wire logic reset_pin_val,
  input wire logic reset_pin_oe_n,
  input wire logic sclk_val,
  input wire logic sclk_oe_n,
  input wire logic self_test_pin,
  input wire logic sample_freeze_input,
  input wire logic status_val,
  input wire logic status_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned hiz_cnt;
  int unsigned stab_cnt;
  int unsigned rst_cnt;
  logic        qual;
  assign qual = !reset_pin_oe_n && !reset_pin_val && !sclk_oe_n && sclk_val;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hiz_cnt <= 0;
      stab_cnt <= 0;
      rst_cnt <= 0;
    end else begin
      hiz_cnt <= status_oe_n ? hiz_cnt + 1 : 0;
      stab_cnt <= status_oe_n ? 0 : (stab_cnt < STAB_CYC ? stab_cnt + 1 : stab_cnt);
      rst_cnt <= qual ? (rst_cnt < 2 * RST_CYC ? rst_cnt + 1 : rst_cnt) : 0;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_hiz_len;
    $fell(status_oe_n) |-> hiz_cnt + 1 >= HIZ_CYC && hiz_cnt <= HIZ_CYC + 2;
  endproperty
  a_hiz_len: assert property (p_hiz_len) else $error("float time wrong");
  property p_hiz_min;
    $rose(status_oe_n) |-> status_oe_n [*8];
  endproperty
  a_hiz_min: assert property (p_hiz_min) else $error("float ended early");
  property p_end_high;
    $fell(status_oe_n) |-> status_val;
  endproperty
  a_end_high: assert property (p_end_high) else $error("status not high at drive");
  property p_hiz_val;
    status_oe_n |-> status_val;
  endproperty
  a_hiz_val: assert property (p_hiz_val) else $error("status low after reset");
  property p_stab;
    (!status_oe_n && stab_cnt + 1 < STAB_CYC) |-> status_val;
  endproperty
  a_stab: assert property (p_stab) else $error("status cleared in delay");
  property p_clear;
    ($fell(status_val) && !status_oe_n) |-> $past(self_test_pin, 1) || $past(self_test_pin, 2);
  endproperty
  a_clear: assert property (p_clear) else $error("status cleared without edge");
  property p_ctl_hold;
    $fell(reset_pin_oe_n) |-> (qual) [*8];
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("reset hold broken");
  property p_dev_rst;
    $rose(status_oe_n) |-> rst_cnt >= RST_CYC;
  endproperty
  a_dev_rst: assert property (p_dev_rst) else $error("reset without full hold");
endmodule

// *** bench/accel_status_hold_reset_ctrl_tb.sv ***
// Bench joining device and controller ends, with a data model.
// Assumes reduced counts 16, 20, 40 on the device end and monitor; the controller takes only the 16.
module accel_status_hold_reset_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RST = 16;
  localparam int HIZ = 20;
  localparam int STB = 40;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] flt = 4'h0;
  ashrc_pkg::ashrc_data_t xs = 16'h0000;
  ashrc_pkg::ashrc_data_t ys = 16'h0000;
  ashrc_pkg::ashrc_data_t xd, yd, ex, ey;
  logic rq = 1'b0, cq = 1'b0, st = 1'b0, frz = 1'b0;
  logic stb, sta, spe, dres, sbusy, fault, shiz, busy, v;
  logic hz = 1'b1, fl = 1'b0;
  int bad_count, comparisons, cyc, last, n, seed;
  ashrc_if ifc ();
  ashrc_dev #(.RST_CYC(RST), .HIZ_CYC(HIZ), .STAB_CYC(STB)) u_ashrc_dev (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .pins(ifc.dev),
    .parity_fault_i(flt[0]), .over_temp_i(flt[1]), .clk_fault_i(flt[2]), .terminal_fault_i(flt[3]),
    .x_sample_i(xs), .y_sample_i(ys), .sample_strobe_o(stb), .x_dac_o(xd), .y_dac_o(yd),
    .self_test_active_o(sta), .serial_port_en_o(spe), .dev_reset_o(dres), .stab_busy_o(sbusy));
  ashrc_ctl #(.RST_CYC(RST)) u_ashrc_ctl (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .pins(ifc.ctl), .reset_req_i(rq),
    .clear_req_i(cq), .self_test_i(st), .freeze_i(frz), .fault_o(fault), .status_hiz_o(shiz), .busy_o(busy));
  ashrc_monitor #(.RST_CYC(RST), .HIZ_CYC(HIZ), .STAB_CYC(STB)) u_mon (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .reset_pin_val(ifc.reset_pin_val),
    .reset_pin_oe_n(ifc.reset_pin_oe_n), .sclk_val(ifc.sclk_val), .sclk_oe_n(ifc.sclk_oe_n),
    .self_test_pin(ifc.self_test_pin), .sample_freeze_input(ifc.sample_freeze_input),
    .status_val(ifc.status_val), .status_oe_n(ifc.status_oe_n));
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("mismatches=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Clear through the controller, then sample status
  task automatic clr(output logic r);
    @(posedge core_clk_i) cq <= 1'b1;
    @(posedge core_clk_i) cq <= 1'b0;
    n = 0;
    @(negedge core_clk_i);
    while (busy !== 1'b0 && n < 50) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(busy, 1'b0);
    repeat (5) @(negedge core_clk_i);
    r = ifc.status_val;
  endtask
  // Stimulus, sample model, strobe period and cycle counter
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ex = 16'h0000;
      ey = 16'h0000;
      last = -1;
    end else begin
      cyc++;
      if (dres === 1'b1) begin
        ex = 16'h0000;
        ey = 16'h0000;
        last = -1;
      end else if (stb === 1'b1 && !frz) begin
        ex = xs;
        ey = ys;
      end
      if (stb === 1'b1) begin
        if (last >= 0) chk(cyc - last, ashrc_pkg::SAMPLE_CYC);
        last = cyc;
      end
      xs <= 16'($random(seed));
      ys <= 16'($random(seed));
    end
  end
  always @(negedge core_clk_i) begin
    if (rstn_i) begin
      chk(xd, ex);
      chk(yd, ey);
      chk(shiz, hz);
      chk(fault, fl);
      hz = ifc.status_oe_n;
      fl = !ifc.status_oe_n && ifc.status_val;
    end
    if (cyc >= 8000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    seed = 32'h7831_187b;
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    n = 0;
    @(negedge core_clk_i);
    while (ifc.status_oe_n !== 1'b0 && n < 200) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(n >= HIZ - 2 && n <= HIZ + 2, 1);
    chk(ifc.status_val, 1);
    clr(v);
    chk(v, 1);
    n = 0;
    while (sbusy !== 1'b0 && n < 200) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(sbusy, 1'b0);
    clr(v);
    chk(v, 0);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i) flt <= 4'(1 << i);
      repeat (3) @(negedge core_clk_i);
      chk(ifc.status_val, 1);
      clr(v);
      chk(v, 1);
      @(posedge core_clk_i) flt <= 4'h0;
      clr(v);
      chk(v, 0);
    end
    @(posedge core_clk_i) st <= 1'b1;
    repeat (3) @(negedge core_clk_i);
    chk(sta, 1);
    @(posedge core_clk_i) flt <= 4'h2;
    @(posedge core_clk_i) flt <= 4'h0;
    repeat (10) @(negedge core_clk_i);
    chk(ifc.status_val, 1);
    @(posedge core_clk_i) st <= 1'b0;
    clr(v);
    chk(v, 0);
    @(posedge core_clk_i) frz <= 1'b1;
    repeat (1000) @(posedge core_clk_i);
    frz <= 1'b0;
    repeat (1000) @(posedge core_clk_i);
    rq <= 1'b1;
    @(posedge core_clk_i) rq <= 1'b0;
    n = 0;
    while (dres !== 1'b1 && n < 100) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(n >= RST && n <= RST + 4, 1);
    @(negedge core_clk_i);
    chk(ifc.status_oe_n, 1);
    chk(spe, 0);
    repeat (HIZ + STB + 40) @(negedge core_clk_i);
    chk(sbusy, 0);
    final_report();
  end
endmodule
